// [verilog/eecl_pkg.sv]
`default_nettype none
package eecl_pkg;
	// Serial bus rate, clock rate and the quarter bit time derived from them
	localparam int CLK_FREQ_KHZ = 250000;
	localparam int SCL_FREQ_KHZ = 400;
	localparam int QTR_CYC = (CLK_FREQ_KHZ + 4 * SCL_FREQ_KHZ - 1) / (4 * SCL_FREQ_KHZ);
	localparam int DIV_W = 8;

	localparam logic [7:0] EE_DEV_ADDR = 8'hA0;
	localparam logic [7:0] RD_FLAG = 8'h01;
	localparam logic [7:0] OWN_ADDR_BASE = 8'hB0;

	// EEPROM layout
	localparam logic [15:0] HDR_BYTES = 16'h0003;
	localparam logic [15:0] MAP_ENTRY = 16'h0002;
	localparam logic [15:0] CFG_BLK = 16'h0026;
	localparam logic [5:0] CFG_BYTES = 6'h25;
	localparam logic [5:0] SIGDET_BYTE = 6'h0A;
	localparam int HDR_CRC_EN_BIT = 7;
	localparam int HDR_MAP_BIT = 6;
	localparam int HDR_LARGE_BIT = 5;
	localparam int SIGDET_AST_HI = 3;
	localparam int SIGDET_DEA_HI = 1;

	localparam logic [7:0] CRC_FIXED = 8'hA5;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [7:0] CFG_DEFAULT = 8'h00;
	localparam logic [1:0] SIGDET_DEFAULT = 2'h0;

	// Bit slot: quarter phases and bit counter
	localparam logic [1:0] Q_SET = 2'h0;
	localparam logic [1:0] Q_RISE = 2'h1;
	localparam logic [1:0] Q_SAMPLE = 2'h2;
	localparam logic [1:0] Q_LAST = 2'h3;
	localparam logic [3:0] BIT_LAST = 4'h8;

	// Decoded level of the four-level mode select pin
	typedef enum logic [1:0] {MODE_LOW = 2'h0, MODE_R = 2'h1, MODE_FLOAT = 2'h2, MODE_HIGH = 2'h3} eecl_mode_t;
	typedef enum {ST_IDLE, ST_START1, ST_DEVW, ST_ADDRH, ST_ADDRL, ST_START2, ST_DEVR, ST_READ, ST_STOP,
		ST_NEXT, ST_DONE, ST_FAIL} eecl_state_t;
	typedef enum {PH_HDR, PH_MAP, PH_CFG} eecl_phase_t;
endpackage : eecl_pkg
`default_nettype wire

// [verilog/eecl_cfg_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module eecl_cfg_mem (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clr_in,
	input wire logic we_in,
	input wire logic [5:0] waddr_in,
	input wire logic [7:0] wdata_in,
	input wire logic [5:0] raddr_in,
	output logic [7:0] rdata_out
);
	import eecl_pkg::*;

	logic [7:0] mem [int'(CFG_BYTES)];

	genvar i;
	generate
		for (i = 0; i < int'(CFG_BYTES); i++)
		begin : g_entry
			always_ff @(posedge clk_in)
			begin
				if (!rst_n_in || clr_in)
					mem[i] <= CFG_DEFAULT;
				else if (we_in && waddr_in == 6'(i))
					mem[i] <= wdata_in;
			end
		end
	endgenerate

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			rdata_out <= 8'h00;
		else if (raddr_in < CFG_BYTES)
			rdata_out <= mem[raddr_in];
		else
			rdata_out <= 8'h00;
	end
endmodule : eecl_cfg_mem
`default_nettype wire

// [verilog/eecl_loader.sv]
`timescale 1ns/10ps
`default_nettype none
module eecl_loader #(
	// Quarter bit length in clocks; the default gives the 400 kHz serial clock
	parameter int QTR_DIV = eecl_pkg::QTR_CYC
) (
	input wire logic CLOCK_IN,
	input wire logic RST_N_IN,
	input wire eecl_pkg::eecl_mode_t SMBUS_MODE_SELECT_IN,
	input wire logic [3:0] ADDR_STRAP_IN,
	input wire logic LOAD_ENABLE_N_IN,
	output logic LOAD_DONE_N_OUT,
	output logic LOAD_ERROR_OUT,
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE_N_OUT,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N_OUT,
	output logic [7:0] OWN_ADDR_OUT,
	output logic [1:0] SIGDET_ASSERT_SEL_OUT,
	output logic [1:0] SIGDET_DEASSERT_SEL_OUT,
	input wire logic [5:0] CFG_RD_ADDR_IN,
	output logic [7:0] CFG_RD_DATA_OUT
);
	import eecl_pkg::*;

	eecl_mode_t mode_m, mode_s;
	logic [3:0] strap_m, strap_s;
	logic len_m, len_s, scl_m, scl_s, sda_m, sda_s;
	logic master, soft_clr, on_bus, is_byte, is_start, tick, adv, byte_end, last_rd, drive_bit, cfg_we;
	logic [DIV_W-1:0] div_cnt;
	logic [1:0] q;
	logic [3:0] bitn;
	logic [7:0] rx, tx, crc;
	logic nack, scl_low, sda_low, crc_en, map_f, large_f, fail_f, crc_bad, done;
	logic [15:0] ee_addr, map_start, map_addr, blk_addr;
	logic [5:0] rd_cnt, rd_idx, cfg_wr_cnt;
	eecl_state_t state;
	eecl_phase_t phase;

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int k = 0; k < 8; k++)
			r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		return r;
	endfunction : crc8

	// Mode, strap, enable and bus pins from outside pass two flip-flops
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_N_IN)
		begin
			mode_m <= MODE_LOW;
			mode_s <= MODE_LOW;
			strap_m <= 4'h0;
			strap_s <= 4'h0;
			{len_m, len_s, scl_m, scl_s, sda_m, sda_s} <= 6'h3F;
		end
		else
		begin
			mode_m <= SMBUS_MODE_SELECT_IN;
			mode_s <= mode_m;
			strap_m <= ADDR_STRAP_IN;
			strap_s <= strap_m;
			{len_m, scl_m, sda_m} <= {LOAD_ENABLE_N_IN, SCL_IN, SDA_IN};
			{len_s, scl_s, sda_s} <= {len_m, scl_m, sda_m};
		end
	end

	assign master = (mode_s == MODE_FLOAT);
	assign soft_clr = (mode_s == MODE_LOW);

	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_N_IN)
			OWN_ADDR_OUT <= OWN_ADDR_BASE;
		else
			OWN_ADDR_OUT <= OWN_ADDR_BASE + {3'h0, strap_s, 1'b0};
	end

	assign map_addr = HDR_BYTES + {11'h000, strap_s, 1'b0};
	assign blk_addr = HDR_BYTES + 16'(strap_s) * CFG_BLK;

	// Quarter bit timer; holds in the sample quarter while a slave stretches the clock
	assign on_bus = !(state inside {ST_IDLE, ST_NEXT, ST_DONE, ST_FAIL});
	assign tick = (div_cnt == DIV_W'(QTR_DIV - 1));
	assign adv = tick && on_bus && !(q == Q_SAMPLE && !scl_s);

	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_N_IN || !on_bus || tick)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + 1'b1;
	end

	assign is_byte = state inside {ST_DEVW, ST_ADDRH, ST_ADDRL, ST_DEVR, ST_READ};
	assign is_start = state inside {ST_START1, ST_START2};
	assign byte_end = adv && q == Q_LAST && is_byte && bitn == BIT_LAST;
	assign last_rd = (rd_idx == rd_cnt - 6'h01);

	always_comb
	begin
		if (state == ST_DEVW)
			tx = EE_DEV_ADDR;
		else if (state == ST_DEVR)
			tx = EE_DEV_ADDR | RD_FLAG;
		else if (state == ST_ADDRH)
			tx = ee_addr[15:8];
		else if (state == ST_ADDRL)
			tx = ee_addr[7:0];
		else
			tx = 8'h00;
	end

	always_comb
	begin
		if (state == ST_READ)
			drive_bit = (bitn == BIT_LAST) && !last_rd;
		else
			drive_bit = (bitn != BIT_LAST) && !tx[3'h7 - bitn[2:0]];
	end

	// Bit engine: open-drain drive of clock and data, sampling of data
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_N_IN || !master)
		begin
			q <= Q_SET;
			bitn <= 4'h0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			rx <= 8'h00;
			nack <= 1'b0;
		end
		else if (adv)
		begin
			q <= q + 2'h1;
			unique case (q)
				Q_SET:
				begin
					if (is_start)
						sda_low <= 1'b0;
					else if (state == ST_STOP)
						sda_low <= 1'b1;
					else
						sda_low <= drive_bit;
				end
				Q_RISE: scl_low <= 1'b0;
				Q_SAMPLE:
				begin
					if (is_start)
						sda_low <= 1'b1;
					else if (state == ST_STOP)
						sda_low <= 1'b0;
					else if (bitn == BIT_LAST)
						nack <= sda_s;
					else
						rx <= {rx[6:0], sda_s};
				end
				Q_LAST:
				begin
					if (state != ST_STOP)
						scl_low <= 1'b1;
					if (is_byte)
						bitn <= (bitn == BIT_LAST) ? 4'h0 : bitn + 4'h1;
				end
			endcase
		end
	end

	// Transfer sequencer
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_N_IN || !master)
		begin
			state <= ST_IDLE;
			phase <= PH_HDR;
			ee_addr <= 16'h0000;
			rd_cnt <= 6'h00;
			rd_idx <= 6'h00;
			fail_f <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					if (!len_s)
					begin
						phase <= PH_HDR;
						ee_addr <= 16'h0000;
						rd_cnt <= HDR_BYTES[5:0];
						state <= ST_START1;
					end
				end
				ST_START1: if (adv && q == Q_LAST) state <= ST_DEVW;
				ST_START2: if (adv && q == Q_LAST) state <= ST_DEVR;
				ST_DEVW, ST_ADDRH, ST_ADDRL, ST_DEVR:
				begin
					if (byte_end)
					begin
						rd_idx <= 6'h00;
						if (nack)
						begin
							fail_f <= 1'b1;
							state <= ST_STOP;
						end
						else if (state == ST_DEVW)
							state <= large_f ? ST_ADDRH : ST_ADDRL;
						else if (state == ST_ADDRH)
							state <= ST_ADDRL;
						else if (state == ST_ADDRL)
							state <= ST_START2;
						else
							state <= ST_READ;
					end
				end
				ST_READ:
				begin
					if (byte_end)
					begin
						rd_idx <= rd_idx + 6'h01;
						if (last_rd)
							state <= ST_STOP;
					end
				end
				ST_STOP: if (adv && q == Q_LAST) state <= ST_NEXT;
				ST_NEXT:
				begin
					if (fail_f || crc_bad)
						state <= ST_FAIL;
					else if (phase == PH_HDR)
					begin
						state <= ST_START1;
						phase <= map_f ? PH_MAP : PH_CFG;
						ee_addr <= map_f ? map_addr : blk_addr;
						rd_cnt <= map_f ? MAP_ENTRY[5:0] : CFG_BLK[5:0];
					end
					else if (phase == PH_MAP)
					begin
						state <= ST_START1;
						phase <= PH_CFG;
						ee_addr <= map_start;
						rd_cnt <= CFG_BLK[5:0];
					end
					else
					begin
						state <= ST_DONE;
						done <= 1'b1;
					end
				end
				ST_DONE, ST_FAIL:
				begin
				end
			endcase
		end
	end

	// Header flags and map entry
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_N_IN || !master)
		begin
			{crc_en, map_f, large_f} <= 3'h0;
			map_start <= 16'h0000;
		end
		else if (byte_end && state == ST_READ && phase == PH_HDR && rd_idx == 6'h00)
		begin
			crc_en <= rx[HDR_CRC_EN_BIT];
			map_f <= rx[HDR_MAP_BIT];
			large_f <= rx[HDR_LARGE_BIT];
		end
		else if (byte_end && state == ST_READ && phase == PH_MAP)
		begin
			if (rd_idx == 6'h00)
				map_start[15:8] <= rx;
			else
				map_start[7:0] <= rx;
		end
	end

	// Configuration bytes, check byte and threshold fields
	assign cfg_we = byte_end && state == ST_READ && phase == PH_CFG && rd_idx < CFG_BYTES;

	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_N_IN || !master || state == ST_IDLE)
		begin
			crc <= CRC_INIT;
			crc_bad <= 1'b0;
			cfg_wr_cnt <= 6'h00;
		end
		else if (cfg_we)
		begin
			crc <= crc8(crc, rx);
			cfg_wr_cnt <= cfg_wr_cnt + 6'h01;
		end
		else if (byte_end && state == ST_READ && phase == PH_CFG)
			crc_bad <= (rx != (crc_en ? crc : CRC_FIXED));
	end

	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_N_IN || soft_clr)
		begin
			SIGDET_ASSERT_SEL_OUT <= SIGDET_DEFAULT;
			SIGDET_DEASSERT_SEL_OUT <= SIGDET_DEFAULT;
		end
		else if (cfg_we && rd_idx == SIGDET_BYTE)
		begin
			SIGDET_ASSERT_SEL_OUT <= rx[SIGDET_AST_HI -: 2];
			SIGDET_DEASSERT_SEL_OUT <= rx[SIGDET_DEA_HI -: 2];
		end
	end

	eecl_cfg_mem u_mem (
		.clk_in(CLOCK_IN),
		.rst_n_in(RST_N_IN),
		.clr_in(soft_clr),
		.we_in(cfg_we),
		.waddr_in(rd_idx),
		.wdata_in(rx),
		.raddr_in(CFG_RD_ADDR_IN),
		.rdata_out(CFG_RD_DATA_OUT)
	);

	assign SCL_OUT = 1'b0;
	assign SDA_OUT = 1'b0;
	assign SCL_OE_N_OUT = !scl_low;
	assign SDA_OE_N_OUT = !sda_low;
	assign LOAD_DONE_N_OUT = !(done && !len_s);
	assign LOAD_ERROR_OUT = (state == ST_FAIL);

	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN);

	start_needs_en_a: assert property (state == ST_IDLE ##1 state == ST_START1 |-> $past(!len_s && master))
		else $error("load started without enable");
	done_after_load_a: assert property ($rose(done) |-> $past(state) == ST_NEXT && phase == PH_CFG)
		else $error("done without finished load");
	bus_released_a: assert property (state == ST_DONE |-> SCL_OE_N_OUT && SDA_OE_N_OUT)
		else $error("bus held after load");
	cfg_count_a: assert property ($rose(done) |-> cfg_wr_cnt == 6'h25)
		else $error("wrong config byte count");
	crc_ok_a: assert property (state == ST_NEXT && crc_bad |=> state == ST_FAIL && !done)
		else $error("done despite check byte mismatch");
	mode_clear_a: assert property (soft_clr |=> !done && SIGDET_ASSERT_SEL_OUT == 2'h0 ##1 LOAD_DONE_N_OUT)
		else $error("defaults not restored");
	own_addr_a: assert property ($stable(strap_s) [*2] |-> OWN_ADDR_OUT == 8'hB0 + 8'(strap_s) * 8'h02)
		else $error("own address wrong");
	addrh_large_a: assert property (state == ST_ADDRH |-> large_f)
		else $error("two byte address without flag");
	dev_byte_a: assert property (state == ST_DEVW |-> tx == 8'hA0)
		else $error("wrong EEPROM device address");
	blk_start_a: assert property (phase == PH_CFG && !map_f && state == ST_START1 |-> ee_addr == 16'h0003 + 16'(strap_s) * 16'h0026)
		else $error("block start address wrong");

	load_done_c: cover property ($rose(done));
	load_fail_c: cover property ($rose(LOAD_ERROR_OUT));
	map_used_c: cover property (phase == PH_MAP && state == ST_READ);
	large_used_c: cover property (state == ST_ADDRH);
endmodule : eecl_loader
`default_nettype wire

// [tb/eecl_eeprom_model.sv]
`timescale 1ns/10ps
`default_nettype none
module eecl_eeprom_model (
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic nack_in,
	input wire logic stretch_in,
	output logic scl_oe_n_out,
	output logic sda_oe_n_out
);
	logic [7:0] mem [0:511];
	logic [7:0] sh;
	logic [7:0] ob;
	logic [15:0] ptr;
	logic first;
	logic sel;
	logic rd;
	logic mnak;
	int cnt;
	int nrd;
	initial
	begin
		scl_oe_n_out = 1'b1;
		sda_oe_n_out = 1'b1;
		nrd = 0;
		sel = 1'b0;
		rd = 1'b0;
	end
	always @(negedge sda_in)
		if (scl_in === 1'b1)
		begin
			// The clock fall that ends a start is not a bit
			cnt = -1;
			first = 1'b1;
			rd = 1'b0;
		end
	always @(posedge sda_in)
		if (scl_in === 1'b1)
			sel = 1'b0;
	// Edge driven, so any bus rate the master uses is served
	always @(posedge scl_in)
		if (cnt < 8)
			sh = {sh[6:0], sda_in};
		else
			mnak = sda_in;
	always @(negedge scl_in)
	begin
		if (cnt == 7 && rd)
			sda_oe_n_out = 1'b1;
		else if (cnt == 7)
		begin
			if (first)
			begin
				sel = (sh[7:1] == 7'h50) && !nack_in;
				rd = sh[0];
				mnak = 1'b0;
				// A read selection keeps the pointer set before the repeated start
				if (!sh[0])
					ptr = 16'h0000;
			end
			else if (sel)
				ptr = {ptr[7:0], sh};
			first = 1'b0;
			sda_oe_n_out = !sel;
		end
		else if (cnt == 8 && rd && sel && !mnak)
		begin
			ob = mem[ptr[8:0]];
			ptr = ptr + 16'h0001;
			nrd++;
			sda_oe_n_out = ob[7];
		end
		else if (cnt == 8)
			sda_oe_n_out = 1'b1;
		else if (rd && sel)
			sda_oe_n_out = ob[6 - cnt];
		cnt = (cnt == 8) ? 0 : cnt + 1;
		// Slow answer: hold the clock low past the master's release and its sample point
		if (stretch_in)
		begin
			scl_oe_n_out = 1'b0;
			#130;
			scl_oe_n_out = 1'b1;
		end
	end
endmodule : eecl_eeprom_model
`default_nettype wire

// [tb/tb_eecl_loader.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_eecl_loader;
	import eecl_pkg::*;
	// Short quarter keeps the run brief: 40 ns quarters give a 160 ns serial clock
	localparam int QTR = 10;
	logic clk, rst_n, en_n, nack, stretch, bus_act;
	logic done_n, err, scl_oe_n, sda_oe_n, m_scl_oe_n, m_sda_oe_n;
	logic [3:0] strap;
	logic [5:0] rd_addr;
	logic [7:0] own, rdat, d, crc;
	logic [1:0] sd_a, sd_d;
	logic [7:0] cfg [0:36];
	eecl_mode_t mode;
	int err_total, n_tests, i;
	wire scl = scl_oe_n & m_scl_oe_n;
	wire sda = sda_oe_n & m_sda_oe_n;
	eecl_loader #(.QTR_DIV(QTR)) uut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .SMBUS_MODE_SELECT_IN(mode),
		.ADDR_STRAP_IN(strap),
		.LOAD_ENABLE_N_IN(en_n), .LOAD_DONE_N_OUT(done_n), .LOAD_ERROR_OUT(err), .SCL_IN(scl), .SCL_OUT(),
		.SCL_OE_N_OUT(scl_oe_n), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_N_OUT(sda_oe_n), .OWN_ADDR_OUT(own),
		.SIGDET_ASSERT_SEL_OUT(sd_a), .SIGDET_DEASSERT_SEL_OUT(sd_d), .CFG_RD_ADDR_IN(rd_addr),
		.CFG_RD_DATA_OUT(rdat));
	eecl_eeprom_model ee (.scl_in(scl), .sda_in(sda), .nack_in(nack), .stretch_in(stretch),
		.scl_oe_n_out(m_scl_oe_n), .sda_oe_n_out(m_sda_oe_n));
	always @(negedge scl or negedge sda)
		bus_act = 1'b1;
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rd(input logic [5:0] a, output logic [7:0] q);
		@(posedge clk);
		#1 rd_addr = a;
		@(posedge clk);
		#1 q = rdat;
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic tend(input string nm);
		$display("end of test %s", nm);
	endtask : tend
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		#400000;
		err_total++;
		results();
	end
	initial
	begin
		rst_n = 1'b0;
		en_n = 1'b1;
		nack = 1'b0;
		stretch = 1'b0;
		mode = MODE_HIGH;
		strap = 4'h0;
		rd_addr = 6'h00;
		bus_act = 1'b0;
		err_total = 0;
		n_tests = 0;
		crc = 8'h00;
		for (i = 0; i < 37; i++)
		begin
			cfg[i] = (i == 10) ? 8'h09 : 8'(i * 29 + 64);
			crc ^= cfg[i];
			repeat (8) crc = crc[7] ? {crc[6:0], 1'b0} ^ 8'h07 : {crc[6:0], 1'b0};
		end
		for (i = 0; i < 512; i++)
			ee.mem[i] = 8'(~i);
		ee.mem[0] = 8'hE0;
		ee.mem[1] = 8'h00;
		ee.mem[2] = 8'h00;
		ee.mem[5] = 8'h01;
		ee.mem[6] = 8'h50;
		for (i = 0; i < 37; i++)
			ee.mem[16'h0150 + i] = cfg[i];
		ee.mem[16'h0175] = crc;
		cyc(8);
		rst_n = 1'b1;
		en_n = 1'b0;
		for (i = 0; i < 16; i++)
		begin
			strap = 4'(i);
			cyc(6);
			chk("own address", 16'(8'hB0 + 2 * i), own);
		end
		chk("bus idle unless float", 16'h0, bus_act);
		tend("straps");
		mode = MODE_FLOAT;
		en_n = 1'b1;
		strap = 4'h1;
		bus_act = 1'b0;
		cyc(2000);
		chk("bus idle while disabled", 16'h0, bus_act);
		chk("done while disabled", 16'h1, done_n);
		tend("enable");
		en_n = 1'b0;
		stretch = 1'b1;
		for (i = 0; i < 40000 && done_n !== 1'b0; i++)
			cyc(1);
		chk("load done", 16'h0, done_n);
		chk("load error", 16'h0, err);
		chk("bytes fetched", 16'd43, 16'(ee.nrd));
		chk("scl released", 16'h1, scl_oe_n);
		chk("sda released", 16'h1, sda_oe_n);
		for (i = 0; i < 38; i++)
		begin
			rd(6'(i), d);
			chk("config byte", (i < 37) ? cfg[i] : 8'h00, d);
		end
		chk("assert threshold", 16'h2, sd_a);
		chk("deassert threshold", 16'h1, sd_d);
		en_n = 1'b1;
		cyc(4);
		chk("done follows enable", 16'h1, done_n);
		mode = MODE_R;
		cyc(6);
		rd(6'h0A, d);
		chk("kept byte", 16'(cfg[10]), d);
		chk("kept threshold", 16'h2, sd_a);
		mode = MODE_LOW;
		cyc(6);
		rd(6'h0A, d);
		chk("cleared byte", 16'h0, d);
		chk("cleared threshold", 16'h0, sd_a);
		tend("load");
		ee.mem[0] = 8'h00;
		for (i = 0; i < 37; i++)
			ee.mem[16'h0029 + i] = cfg[i];
		ee.mem[16'h004E] = 8'hA5;
		ee.nrd = 0;
		stretch = 1'b0;
		mode = MODE_FLOAT;
		en_n = 1'b0;
		for (i = 0; i < 30000 && done_n !== 1'b0 && err !== 1'b1; i++)
			cyc(1);
		chk("plain load done", 16'h0, done_n);
		chk("plain load error", 16'h0, err);
		chk("plain bytes fetched", 16'd41, 16'(ee.nrd));
		for (i = 0; i < 37; i += 9)
		begin
			rd(6'(i), d);
			chk("plain config byte", 16'(cfg[i]), d);
		end
		tend("plain");
		mode = MODE_LOW;
		cyc(6);
		ee.mem[16'h004E] = 8'h5A;
		mode = MODE_FLOAT;
		for (i = 0; i < 30000 && err !== 1'b1; i++)
			cyc(1);
		chk("check byte refused", 16'h1, err);
		chk("done after bad check", 16'h1, done_n);
		tend("check byte");
		mode = MODE_LOW;
		cyc(6);
		nack = 1'b1;
		stretch = 1'b0;
		mode = MODE_FLOAT;
		en_n = 1'b0;
		for (i = 0; i < 20000 && err !== 1'b1; i++)
			cyc(1);
		chk("refused address", 16'h1, err);
		cyc(2000);
		chk("done after refusal", 16'h1, done_n);
		chk("bus after refusal", 16'h3, {scl_oe_n, sda_oe_n});
		tend("refusal");
		results();
	end
endmodule : tb_eecl_loader
`default_nettype wire
